// ===== design/ald_regs.vh
// Register map, field positions, reset values and opcodes of the accumulator load decoder
`ifndef ALD_REGS_VH
`define ALD_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ALD_OFS_WAKE1      6'h00
`define ALD_OFS_WAKE2      6'h04
`define ALD_OFS_LEVEL      6'h08
`define ALD_OFS_CLKCTL     6'h0c
`define ALD_OFS_PULL0      6'h10
`define ALD_OFS_PULL1      6'h14
`define ALD_OFS_PULL2      6'h18
`define ALD_OFS_ACC        6'h1c
`define ALD_OFS_FILESEL    6'h20
`define ALD_OFS_DPTR       6'h24
`define ALD_OFS_RAMWIN     6'h28
`define ALD_OFS_STATUS     6'h2c
`define ALD_OFS_EXECCNT    6'h30

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define ALD_NIB_W          4
`define ALD_INSTR_W        10
`define ALD_STAT_CARRY     0
`define ALD_STAT_SKIP      1
`define ALD_STAT_UNHANDLED 2
`define ALD_CNT_W          16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ALD_RST_NIB        4'h0
`define ALD_RST_CNT        16'h0000

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define ALD_OP_WAKE1       10'h259
`define ALD_OP_WAKE2       10'h25a
`define ALD_OP_LEVEL       10'h24a
`define ALD_OP_CLKCTL      10'h252
`define ALD_OP_PULL0       10'h257
`define ALD_OP_PULL1       10'h25e
`define ALD_OP_PULL2       10'h25f
`define ALD_OP_RAM_HI      6'h2c

// ----------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------
`define ALD_SRC_WAKE1      3'h0
`define ALD_SRC_WAKE2      3'h1
`define ALD_SRC_LEVEL      3'h2
`define ALD_SRC_CLKCTL     3'h3
`define ALD_SRC_PULL0      3'h4
`define ALD_SRC_PULL1      3'h5
`define ALD_SRC_PULL2      3'h6
`define ALD_SRC_RAM        3'h7

`endif

// ===== design/ald_decode.v
// Opcode decoder for the accumulator load group
`timescale 1ns/1ps
`include "ald_regs.vh"

module ald_decode (
    // Instruction word
    input  wire [9:0] instr,
    // Decode result
    output wire       hit,
    output wire [2:0] src_sel,
    output wire [3:0] imm
);

    // ----------------------------------------------------------------
    // Decode function: bit 3 is the hit flag, bits 2..0 the source
    // ----------------------------------------------------------------
    function [3:0] ald_dec;
        input [9:0] op;
        begin
            if (op[9:4] == `ALD_OP_RAM_HI) begin
                ald_dec = {1'b1, `ALD_SRC_RAM};
            end else if (op == `ALD_OP_WAKE1) begin
                ald_dec = {1'b1, `ALD_SRC_WAKE1};
            end else if (op == `ALD_OP_WAKE2) begin
                ald_dec = {1'b1, `ALD_SRC_WAKE2};
            end else if (op == `ALD_OP_LEVEL) begin
                ald_dec = {1'b1, `ALD_SRC_LEVEL};
            end else if (op == `ALD_OP_CLKCTL) begin
                ald_dec = {1'b1, `ALD_SRC_CLKCTL};
            end else if (op == `ALD_OP_PULL0) begin
                ald_dec = {1'b1, `ALD_SRC_PULL0};
            end else if (op == `ALD_OP_PULL1) begin
                ald_dec = {1'b1, `ALD_SRC_PULL1};
            end else if (op == `ALD_OP_PULL2) begin
                ald_dec = {1'b1, `ALD_SRC_PULL2};
            end else begin
                ald_dec = 4'h0;
            end
        end
    endfunction

    // Whole ten-bit word decoded at once, one word per instruction
    wire [3:0] dec_word;

    assign dec_word = ald_dec(instr);
    assign hit      = dec_word[3];
    assign src_sel  = dec_word[2:0];
    assign imm      = instr[3:0];

endmodule

// ===== design/ald_ram.v
// Sixteen-nibble data RAM, written from the bus and read at the data pointer
`timescale 1ns/1ps
`include "ald_regs.vh"

module ald_ram (
    // Clock
    input  wire       clk,
    // Write port
    input  wire       we,
    input  wire [3:0] waddr,
    input  wire [3:0] wdata,
    // Read port
    input  wire [3:0] raddr,
    output wire [3:0] rdata
);

    reg [3:0] mem [0:15];

    // ----------------------------------------------------------------
    // Storage, no reset so it maps onto plain memory
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Asynchronous read so an instruction sees RAM in its own cycle
    assign rdata = mem[raddr];

endmodule

// ===== design/ald_core.v
// Accumulator load group: decode, execution and Avalon-MM register slave
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "ald_regs.vh"

module ald_core (
    // Clock and reset
    input  wire        REF_CLK,
    input  wire        RST_N,
    // Instruction fetch
    input  wire [9:0]  INSTR_WORD,
    input  wire        INSTR_VALID,
    // Avalon-MM slave
    input  wire [5:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    output reg  [31:0] AVS_READDATA,
    output reg         AVS_WAITREQUEST,
    // Core state
    output reg  [3:0]  ACC,
    output reg  [3:0]  FILE_SEL,
    output reg         CARRY,
    output reg         SKIP,
    output reg         EXEC_DONE
);

    // ----------------------------------------------------------------
    // Register select bit positions
    // ----------------------------------------------------------------
    // Internal strobe order only; software sees the byte offsets
    localparam SEL_WAKE1   = 0;
    localparam SEL_WAKE2   = 1;
    localparam SEL_LEVEL   = 2;
    localparam SEL_CLKCTL  = 3;
    localparam SEL_PULL0   = 4;
    localparam SEL_PULL1   = 5;
    localparam SEL_PULL2   = 6;
    localparam SEL_ACC     = 7;
    localparam SEL_FILESEL = 8;
    localparam SEL_DPTR    = 9;
    localparam SEL_RAMWIN  = 10;
    localparam SEL_STATUS  = 11;
    localparam SEL_EXECCNT = 12;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // One copy of the map, so a read and a write of one offset never disagree
    function [12:0] ald_reg_sel;
        input [5:0] addr;
        begin
            ald_reg_sel = 13'h0000;
            if (addr == `ALD_OFS_WAKE1) begin
                ald_reg_sel[SEL_WAKE1] = 1'b1;
            end else if (addr == `ALD_OFS_WAKE2) begin
                ald_reg_sel[SEL_WAKE2] = 1'b1;
            end else if (addr == `ALD_OFS_LEVEL) begin
                ald_reg_sel[SEL_LEVEL] = 1'b1;
            end else if (addr == `ALD_OFS_CLKCTL) begin
                ald_reg_sel[SEL_CLKCTL] = 1'b1;
            end else if (addr == `ALD_OFS_PULL0) begin
                ald_reg_sel[SEL_PULL0] = 1'b1;
            end else if (addr == `ALD_OFS_PULL1) begin
                ald_reg_sel[SEL_PULL1] = 1'b1;
            end else if (addr == `ALD_OFS_PULL2) begin
                ald_reg_sel[SEL_PULL2] = 1'b1;
            end else if (addr == `ALD_OFS_ACC) begin
                ald_reg_sel[SEL_ACC] = 1'b1;
            end else if (addr == `ALD_OFS_FILESEL) begin
                ald_reg_sel[SEL_FILESEL] = 1'b1;
            end else if (addr == `ALD_OFS_DPTR) begin
                ald_reg_sel[SEL_DPTR] = 1'b1;
            end else if (addr == `ALD_OFS_RAMWIN) begin
                ald_reg_sel[SEL_RAMWIN] = 1'b1;
            end else if (addr == `ALD_OFS_STATUS) begin
                ald_reg_sel[SEL_STATUS] = 1'b1;
            end else if (addr == `ALD_OFS_EXECCNT) begin
                ald_reg_sel[SEL_EXECCNT] = 1'b1;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg  [3:0]  wake1_reg;
    reg  [3:0]  wake2_reg;
    reg  [3:0]  level_reg;
    reg  [3:0]  clkctl_reg;
    reg  [3:0]  pull0_reg;
    reg  [3:0]  pull1_reg;
    reg  [3:0]  pull2_reg;
    reg  [3:0]  dptr_reg;
    reg         unhandled_reg;
    reg  [15:0] cnt_reg;
    reg  [31:0] rdata_next;
    wire        dec_hit;
    wire [2:0]  dec_src;
    wire [3:0]  dec_imm;
    wire [3:0]  ram_rdata;
    reg  [3:0]  src_nib;
    wire        bus_req;
    wire        bus_wr;
    wire        ram_we;
    // Decoded selects and instruction strobes
    wire [12:0] reg_sel;
    wire [12:0] wr_sel;
    wire        ins_fire;
    wire        ins_ram;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    ald_decode u_dec (
        .instr   (INSTR_WORD),
        .hit     (dec_hit),
        .src_sel (dec_src),
        .imm     (dec_imm)
    );

    ald_ram u_ram (
        .clk   (REF_CLK),
        .we    (ram_we),
        .waddr (dptr_reg),
        .wdata (AVS_WRITEDATA[3:0]),
        .raddr (dptr_reg),
        .rdata (ram_rdata)
    );

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // A write lands only in the cycle the master sees waitrequest low
    assign bus_req  = AVS_READ | AVS_WRITE;
    assign bus_wr   = AVS_WRITE & ~AVS_WAITREQUEST;
    assign reg_sel  = ald_reg_sel(AVS_ADDRESS);
    assign wr_sel   = {13{bus_wr}} & reg_sel;
    assign ram_we   = wr_sel[SEL_RAMWIN];

    // Instruction strobes; a word only counts while fetch marks it valid
    assign ins_fire = INSTR_VALID & dec_hit;
    assign ins_ram  = ins_fire & (dec_src == `ALD_SRC_RAM);

    // Source multiplexer; every source is a full nibble
    always @* begin
        case (dec_src)
            `ALD_SRC_WAKE1:  src_nib = wake1_reg;
            `ALD_SRC_WAKE2:  src_nib = wake2_reg;
            `ALD_SRC_LEVEL:  src_nib = level_reg;
            `ALD_SRC_CLKCTL: src_nib = clkctl_reg;
            `ALD_SRC_PULL0:  src_nib = pull0_reg;
            `ALD_SRC_PULL1:  src_nib = pull1_reg;
            `ALD_SRC_PULL2:  src_nib = pull2_reg;
            default:         src_nib = ram_rdata;
        endcase
    end

    // Read data mux; unmapped offsets read zero
    always @* begin
        rdata_next = 32'h0000_0000;
        if (reg_sel[SEL_WAKE1]) begin
            rdata_next[3:0] = wake1_reg;
        end else if (reg_sel[SEL_WAKE2]) begin
            rdata_next[3:0] = wake2_reg;
        end else if (reg_sel[SEL_LEVEL]) begin
            rdata_next[3:0] = level_reg;
        end else if (reg_sel[SEL_CLKCTL]) begin
            rdata_next[3:0] = clkctl_reg;
        end else if (reg_sel[SEL_PULL0]) begin
            rdata_next[3:0] = pull0_reg;
        end else if (reg_sel[SEL_PULL1]) begin
            rdata_next[3:0] = pull1_reg;
        end else if (reg_sel[SEL_PULL2]) begin
            rdata_next[3:0] = pull2_reg;
        end else if (reg_sel[SEL_ACC]) begin
            rdata_next[3:0] = ACC;
        end else if (reg_sel[SEL_FILESEL]) begin
            rdata_next[3:0] = FILE_SEL;
        end else if (reg_sel[SEL_DPTR]) begin
            rdata_next[3:0] = dptr_reg;
        end else if (reg_sel[SEL_RAMWIN]) begin
            rdata_next[3:0] = ram_rdata;
        end else if (reg_sel[SEL_STATUS]) begin
            // Flags share one word; the skip bit stays zero for this group
            rdata_next[`ALD_STAT_CARRY]     = CARRY;
            rdata_next[`ALD_STAT_SKIP]      = SKIP;
            rdata_next[`ALD_STAT_UNHANDLED] = unhandled_reg;
        end else if (reg_sel[SEL_EXECCNT]) begin
            rdata_next[15:0] = cnt_reg;
        end
    end

    // ----------------------------------------------------------------
    // Bus slave: one wait cycle, then a one-cycle answer
    // ----------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0000_0000;
        end else if (bus_req && AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= rdata_next;
        end else begin
            AVS_WAITREQUEST <= 1'b1;
        end
    end

    // Peripheral sources are software-written, only read by the core
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            wake1_reg  <= `ALD_RST_NIB;
            wake2_reg  <= `ALD_RST_NIB;
            level_reg  <= `ALD_RST_NIB;
            clkctl_reg <= `ALD_RST_NIB;
            pull0_reg  <= `ALD_RST_NIB;
            pull1_reg  <= `ALD_RST_NIB;
            pull2_reg  <= `ALD_RST_NIB;
            dptr_reg   <= `ALD_RST_NIB;
        end else if (bus_wr) begin
            // Read-only and unmapped offsets fall through, so writes there are dropped
            if (reg_sel[SEL_WAKE1]) begin
                wake1_reg <= AVS_WRITEDATA[3:0];
            end else if (reg_sel[SEL_WAKE2]) begin
                wake2_reg <= AVS_WRITEDATA[3:0];
            end else if (reg_sel[SEL_LEVEL]) begin
                level_reg <= AVS_WRITEDATA[3:0];
            end else if (reg_sel[SEL_CLKCTL]) begin
                clkctl_reg <= AVS_WRITEDATA[3:0];
            end else if (reg_sel[SEL_PULL0]) begin
                pull0_reg <= AVS_WRITEDATA[3:0];
            end else if (reg_sel[SEL_PULL1]) begin
                pull1_reg <= AVS_WRITEDATA[3:0];
            end else if (reg_sel[SEL_PULL2]) begin
                pull2_reg <= AVS_WRITEDATA[3:0];
            end else if (reg_sel[SEL_DPTR]) begin
                dptr_reg <= AVS_WRITEDATA[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Execution: each decoded instruction retires in one cycle
    // ----------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            ACC       <= `ALD_RST_NIB;
            EXEC_DONE <= 1'b0;
            SKIP      <= 1'b0;
            cnt_reg   <= `ALD_RST_CNT;
        end else begin
            EXEC_DONE <= ins_fire;
            SKIP      <= 1'b0;
            // Whole nibble replaced; the count wraps silently at 16 bits
            if (ins_fire) begin
                ACC     <= src_nib;
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    // File select: instruction XOR wins over a bus write in the same cycle
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            FILE_SEL <= `ALD_RST_NIB;
        end else if (ins_ram) begin
            FILE_SEL <= FILE_SEL ^ dec_imm;
        end else if (wr_sel[SEL_FILESEL]) begin
            FILE_SEL <= AVS_WRITEDATA[3:0];
        end
    end

    // Carry is only touched by software; this group never changes it
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            CARRY <= 1'b0;
        end else if (wr_sel[SEL_STATUS]) begin
            CARRY <= AVS_WRITEDATA[`ALD_STAT_CARRY];
        end
    end

    // Sticky flag for words outside this group; set beats clear
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            unhandled_reg <= 1'b0;
        end else if (INSTR_VALID && !dec_hit) begin
            unhandled_reg <= 1'b1;
        end else if (wr_sel[SEL_STATUS] && AVS_WRITEDATA[`ALD_STAT_UNHANDLED]) begin
            unhandled_reg <= 1'b0;
        end
    end

endmodule

// ===== tb/ald_prog_mem.sv
// Program memory model that streams ten-bit instruction words to the core
`timescale 1ns/1ps

module ald_prog_mem (
    // Clock and reset
    input  logic       clk,
    input  logic       rst_n,
    // Run control
    input  logic       start,
    input  logic [5:0] len,
    // Instruction fetch
    output logic [9:0] instr_word,
    output logic       instr_valid
);
    logic [9:0] mem [0:63];
    logic [5:0] pc_reg;
    logic [5:0] left_reg;

    // One whole word per cycle; the bus toggles when idle so stale words never look valid
    always @(posedge clk) begin
        if (!rst_n) begin
            instr_valid <= 1'b0;
            instr_word  <= 10'h000;
            left_reg    <= 6'h00;
        end else if (start) begin
            instr_word  <= mem[0];
            instr_valid <= 1'b1;
            pc_reg      <= 6'h01;
            left_reg    <= len - 6'h01;
        end else if (left_reg != 6'h00) begin
            instr_word <= mem[pc_reg];
            pc_reg     <= pc_reg + 6'h01;
            left_reg   <= left_reg - 6'h01;
        end else begin
            instr_valid <= 1'b0;
            instr_word  <= ~instr_word;
        end
    end
endmodule

// ===== tb/ald_core_sva.sv
// Checker for the accumulator load group at the core's ports
`timescale 1ns/1ps

module ald_core_sva (
    // Clock and reset
    input logic        REF_CLK,
    input logic        RST_N,
    // Instruction fetch
    input logic [9:0]  INSTR_WORD,
    input logic        INSTR_VALID,
    // Bus answer
    input logic [5:0]  AVS_ADDRESS,
    input logic        AVS_READ,
    input logic [31:0] AVS_READDATA,
    input logic        AVS_WAITREQUEST,
    // Core state
    input logic [3:0]  ACC,
    input logic [3:0]  FILE_SEL,
    input logic        CARRY,
    input logic        SKIP,
    input logic        EXEC_DONE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    // Group membership, kept apart so the RAM, foreign-word and done properties read the same decode
    logic ram_op;
    logic grp_op;
    assign ram_op = INSTR_WORD[9:4] == 6'h2c;
    assign grp_op = ram_op || INSTR_WORD inside {10'h259, 10'h25a, 10'h24a, 10'h252,
                                                 10'h257, 10'h25e, 10'h25f};

    property p_wake_ops;
        INSTR_VALID && INSTR_WORD inside {10'h259, 10'h25a, 10'h24a}
            |=> EXEC_DONE && !SKIP && CARRY == $past(CARRY);
    endproperty
    a_wake_ops: assert property (p_wake_ops)
        else $error("wake load not completed");
    property p_ctl_ops;
        INSTR_VALID && INSTR_WORD inside {10'h252, 10'h257, 10'h25e, 10'h25f}
            |=> EXEC_DONE && !SKIP && CARRY == $past(CARRY);
    endproperty
    a_ctl_ops: assert property (p_ctl_ops)
        else $error("control load not completed");
    property p_ram_xor;
        INSTR_VALID && ram_op |=> FILE_SEL == ($past(FILE_SEL) ^ $past(INSTR_WORD[3:0]));
    endproperty
    a_ram_xor: assert property (p_ram_xor)
        else $error("file select not xored");
    property p_ram_done;
        INSTR_VALID && ram_op |=> EXEC_DONE && !SKIP && $stable(CARRY);
    endproperty
    a_ram_done: assert property (p_ram_done)
        else $error("ram load not completed");
    property p_other_hold;
        INSTR_VALID && !grp_op |=> !EXEC_DONE && $stable(ACC) && $stable(FILE_SEL);
    endproperty
    a_other_hold: assert property (p_other_hold)
        else $error("foreign opcode changed state");
    property p_acc_idle;
        !INSTR_VALID |=> $stable(ACC) && !EXEC_DONE;
    endproperty
    a_acc_idle: assert property (p_acc_idle)
        else $error("accumulator moved without instruction");
    property p_done_cause;
        EXEC_DONE |-> $past(INSTR_VALID) && $past(grp_op);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("done without instruction");
    property p_bus_nib;
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS != 6'h30
            |-> AVS_READDATA[31:4] == 28'h0000000;
    endproperty
    a_bus_nib: assert property (p_bus_nib)
        else $error("read data wider than a nibble");
endmodule

bind ald_core ald_core_sva chk (.REF_CLK, .RST_N, .INSTR_WORD, .INSTR_VALID, .AVS_ADDRESS,
    .AVS_READ,
    .AVS_READDATA, .AVS_WAITREQUEST, .ACC, .FILE_SEL, .CARRY, .SKIP, .EXEC_DONE);

// ===== tb/ald_core_bench.sv
// Self-checking bench for the accumulator load group
`timescale 1ns/1ps
`include "ald_regs.vh"

module ald_core_bench;
    logic REF_CLK, RST_N, INSTR_VALID, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
    logic CARRY, SKIP, EXEC_DONE, start, v;
    logic [9:0] INSTR_WORD, w;
    logic [5:0] AVS_ADDRESS, len;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
    logic [3:0] ACC, FILE_SEL;
    integer src [0:6];
    integer ram [0:15];
    integer acc = 0, fsel = 0, dptr = 0, cy = 0, unh = 0, n_exec = 0, edone, i, r;
    integer n_errors = 0, n_tests = 0, seed = 45;

    ald_core uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .INSTR_WORD(INSTR_WORD),
        .INSTR_VALID(INSTR_VALID), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .ACC(ACC), .FILE_SEL(FILE_SEL), .CARRY(CARRY),
        .SKIP(SKIP), .EXEC_DONE(EXEC_DONE));
    ald_prog_mem pm (.clk(REF_CLK), .rst_n(RST_N), .start(start), .len(len),
        .instr_word(INSTR_WORD), .instr_valid(INSTR_VALID));

    // Clock at 40 MHz
    initial begin
        REF_CLK = 1'b0;
        forever #12.5 REF_CLK = ~REF_CLK;
    end

    task final_report;
        begin
            if (n_errors == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task check(input string nm, input [31:0] got, input [31:0] exp);
        begin
            n_tests++;
            if (got !== exp) begin
                $display("mismatch %s expected %h seen %h", nm, exp, got);
                n_errors++;
            end
        end
    endtask

    // One bus cycle; held until waitrequest is sampled low, bounded so a hang ends the run
    task bus(input logic wr, input [5:0] a, input [3:0] d);
        integer k;
        begin
            @(posedge REF_CLK);
            AVS_ADDRESS <= a;
            AVS_WRITEDATA <= {28'h0000000, d};
            AVS_WRITE <= wr;
            AVS_READ <= !wr;
            k = 0;
            do begin
                @(posedge REF_CLK);
                k++;
            end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
            q = AVS_READDATA;
            AVS_WRITE <= 1'b0;
            AVS_READ <= 1'b0;
            if (k >= 50) begin
                n_errors++;
                final_report;
            end
        end
    endtask

    // Reference model: same-edge inputs predict the outputs seen just after that edge
    always @(posedge REF_CLK) begin
        if (RST_N) begin
            v = INSTR_VALID;
            w = INSTR_WORD;
            edone = 0;
            if (v === 1'b1) begin
                edone = 1;
                case (w)
                    10'h259: acc = src[0];
                    10'h25a: acc = src[1];
                    10'h24a: acc = src[2];
                    10'h252: acc = src[3];
                    10'h257: acc = src[4];
                    10'h25e: acc = src[5];
                    10'h25f: acc = src[6];
                    default: if (w[9:4] == 6'h2c) begin
                        acc = ram[dptr];
                        fsel = fsel ^ w[3:0];
                    end else begin
                        edone = 0;
                        unh = 1;
                    end
                endcase
            end
            n_exec = n_exec + edone;
            #1;
            check("acc", ACC, acc);
            check("file_sel", FILE_SEL, fsel);
            check("done", EXEC_DONE, edone);
            check("carry", CARRY, cy);
            check("skip", SKIP, 0);
        end
    end

    // Fills program memory with every group opcode, edge immediates and random words
    task run_prog(input integer nr);
        begin
            pm.mem[0] = 10'h259; pm.mem[1] = 10'h25a; pm.mem[2] = 10'h24a;
            pm.mem[3] = 10'h252; pm.mem[4] = 10'h257; pm.mem[5] = 10'h25e;
            pm.mem[6] = 10'h25f; pm.mem[7] = 10'h2cf; pm.mem[8] = 10'h2c0;
            pm.mem[9] = 10'h2ca; pm.mem[10] = 10'h253; pm.mem[11] = 10'h259;
            for (r = 12; r < 12 + nr; r++)
                pm.mem[r] = 10'($random(seed));
            len <= 6'(12 + nr);
            start <= 1'b1;
            @(posedge REF_CLK);
            start <= 1'b0;
            repeat (16 + nr) @(posedge REF_CLK);
        end
    endtask

    initial begin
        RST_N = 1'b0; start = 1'b0; len = 6'h00; AVS_READ = 1'b0; AVS_WRITE = 1'b0;
        AVS_ADDRESS = 6'h00; AVS_WRITEDATA = 32'h00000000;
        repeat (10) @(posedge REF_CLK);
        RST_N <= 1'b1;
        // Source registers: reset value, then write and read back
        for (i = 0; i < 7; i++) begin
            bus(0, {i[3:0], 2'b00}, 4'h0);
            check("src_rst", q, 0);
            src[i] = $random(seed) & 15;
            bus(1, {i[3:0], 2'b00}, src[i][3:0]);
            bus(0, {i[3:0], 2'b00}, 4'h0);
            check("src_rd", q, src[i]);
        end
        for (i = 0; i < 16; i++) begin
            ram[i] = $random(seed) & 15;
            bus(1, `ALD_OFS_DPTR, i[3:0]);
            bus(1, `ALD_OFS_RAMWIN, ram[i][3:0]);
        end
        bus(0, 6'h3c, 4'h0);
        check("unmapped", q, 0);
        bus(1, `ALD_OFS_STATUS, 4'h1);
        cy = 1;
        // Two runs at a middle and at the last data pointer
        dptr = 5;
        bus(1, `ALD_OFS_DPTR, 4'h5);
        run_prog(6);
        bus(1, `ALD_OFS_FILESEL, 4'h9);
        fsel = 9;
        dptr = 15;
        bus(1, `ALD_OFS_DPTR, 4'hf);
        run_prog(20);
        bus(0, `ALD_OFS_STATUS, 4'h0);
        check("status", q, unh * 4 + cy);
        bus(0, `ALD_OFS_FILESEL, 4'h0);
        check("file_sel_rd", q, fsel);
        bus(0, `ALD_OFS_ACC, 4'h0);
        check("acc_rd", q, acc);
        bus(0, `ALD_OFS_EXECCNT, 4'h0);
        check("exec_cnt", q, n_exec);
        bus(1, `ALD_OFS_STATUS, 4'h5);
        unh = 0;
        bus(0, `ALD_OFS_STATUS, 4'h0);
        check("status_clr", q, unh * 4 + cy);
        final_report;
    end
endmodule
